/* File: cis_pkg.sv */
// Package with constants and types of the core interrupt sequencer.
package cis_pkg;
  // Phase numbers inside one instruction cycle of four clocks.
  localparam logic [1:0] CIS_PHASE_ONE = 2'h0;
  localparam logic [1:0] CIS_PHASE_FOUR = 2'h3;
  // Fixed address that fetching continues from after entry.
  localparam logic [14:0] CIS_VECTOR_ADDR = 15'h0004;
  // Values after reset of the control bits.
  localparam logic CIS_GLOBAL_EN_RESET = 1'h0;
  localparam logic CIS_PERIPH_EN_RESET = 1'h0;
  localparam logic CIS_EDGE_RESET = 1'h1;
  // Forced no-operation cycles during entry.
  localparam int CIS_NOP_CYCLES = 2;

  // Context copied into shadow storage on entry.
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [5:0] bsr;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [6:0] pclath;
  } cis_ctx_t;

  // Software write to the control bits.
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic ext_edge_select;
  } cis_ctrl_t;

  // Commands from the sequencer to the fetch and execute logic.
  typedef struct packed {
    logic flush;
    logic force_nop;
    logic push;
    logic shadow_save;
    logic pc_load;
    logic pop;
    logic restore;
  } cis_cmd_t;

  // Entry sequencer states.
  typedef enum logic [1:0] {
    CIS_ST_RUN,
    CIS_ST_NOP1,
    CIS_ST_NOP2
  } cis_state_t;
endpackage

/* File: cis_core_irq_seq.sv */
// Core interrupt sequencer: flags, enable gating, entry and return sequence.
//
// Contract
// [R1] Any reset leaves all interrupt servicing disabled.
// [R2] Redirect needs global and individual enable set.
// [R3] Peripheral sources also need peripheral enable set.
// [R4] Flags set on events regardless of enables.
// [R5] Accepted interrupt discards the prefetched instruction.
// [R6] Entry clears global enable, pushes PC.
// [R7] Entry copies core context into shadow storage.
// [R8] Entry then loads PC with vector 0004h.
// [R9] Events in handler flag but never redirect.
// [R10] Return pops PC, restores context, sets enable.
// [R11] Pending enabled event served once enable returns.
// [R12] Handler clears serviced flags before returning.
// [R13] Handler polls flags to find the source.
// [R14] Requests sampled once per cycle, phase one.
// [R15] Entry delay depends on executing instruction.
// [R16] Pin flag may set phase four to one.
// [R17] Edge select picks rising or falling pin edge.
// [R18] Entry executes two forced no-operation cycles.
// [R19] Request is OR of gated flag-enable pairs.
`timescale 1ns/1ps
module cis_core_irq_seq import cis_pkg::*; #(
  parameter int NUM_CORE = 4,
  parameter int NUM_PERIPH = 8
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic ext_pin_in,
  input wire logic [NUM_CORE-1:0] core_event_in,
  input wire logic [NUM_PERIPH-1:0] periph_event_in,
  input wire logic ctrl_wr_in,
  input wire cis_ctrl_t ctrl_wdata_in,
  input wire logic core_en_wr_in,
  input wire logic [NUM_CORE-1:0] core_en_wdata_in,
  input wire logic periph_en_wr_in,
  input wire logic [NUM_PERIPH-1:0] periph_en_wdata_in,
  input wire logic [NUM_CORE-1:0] core_flag_clr_in,
  input wire logic [NUM_PERIPH-1:0] periph_flag_clr_in,
  input wire logic instr_boundary_in,
  input wire logic return_from_irq_instr_in,
  input wire logic [14:0] pc_in,
  input wire cis_ctx_t ctx_in,
  output logic [1:0] phase_out,
  output cis_ctrl_t ctrl_out,
  output logic [NUM_CORE-1:0] core_en_out,
  output logic [NUM_PERIPH-1:0] periph_en_out,
  output logic [NUM_CORE-1:0] core_flag_out,
  output logic [NUM_PERIPH-1:0] periph_flag_out,
  output logic irq_request_out,
  output cis_cmd_t cmd_out,
  output logic [14:0] push_pc_out,
  output logic [14:0] load_pc_out,
  output cis_ctx_t shadow_out
);
  logic [1:0] phase_reg;
  logic global_irq_enable_reg;
  logic peripheral_irq_enable_reg;
  logic edge_reg;
  logic [NUM_CORE-1:0] core_en_reg;
  logic [NUM_PERIPH-1:0] periph_en_reg;
  logic [NUM_CORE-1:0] core_flag_reg;
  logic [NUM_PERIPH-1:0] periph_flag_reg;
  logic [NUM_CORE-1:0] core_flag_next;
  logic [NUM_PERIPH-1:0] periph_flag_next;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  logic pin_level_reg;
  logic request_reg;
  cis_state_t state_reg;
  cis_state_t state_next;
  cis_cmd_t cmd_reg;
  cis_cmd_t cmd_next;
  logic [14:0] push_pc_reg;
  logic [14:0] load_pc_reg;
  cis_ctx_t shadow_reg;

  // Pin edge qualification and gated request terms.
  wire pin_agree = (pin_s2_reg == pin_s3_reg);
  wire pin_changed = pin_agree && (pin_s3_reg != pin_level_reg);
  // [R17] Edge select choice.
  wire pin_edge = pin_changed && (pin_s3_reg == edge_reg);
  wire [NUM_CORE-1:0] core_set = {core_event_in[NUM_CORE-1:1], core_event_in[0] | pin_edge};
  // [R2] Individual gating; global gating is added in the request term.
  wire core_any = |(core_flag_reg & core_en_reg);
  // [R3] Peripheral gating added.
  wire periph_any = peripheral_irq_enable_reg && (|(periph_flag_reg & periph_en_reg));
  // [R19] Combined request term.
  wire request_now = global_irq_enable_reg && (core_any || periph_any);
  wire at_phase_one = (phase_reg == CIS_PHASE_ONE);
  // [R14] Sampling only in phase one.
  // [R15] Accept waits for the instruction boundary.
  wire accept = at_phase_one && instr_boundary_in && request_now && (state_reg == CIS_ST_RUN);
  wire do_return = return_from_irq_instr_in && (state_reg == CIS_ST_RUN);

  // Flag update per source; a set in the clear cycle wins.
  // [R4] Flags ignore enables.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CORE; gi++) begin : g_core_flag
      assign core_flag_next[gi] = (core_flag_reg[gi] & ~core_flag_clr_in[gi]) | core_set[gi];
    end
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph_flag
      assign periph_flag_next[gi] =
        (periph_flag_reg[gi] & ~periph_flag_clr_in[gi]) | periph_event_in[gi];
    end
  endgenerate

  // Phase counter; one clock is one phase.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_reg <= CIS_PHASE_ONE;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Three-stage pin synchroniser and settled level.
  // [R16] Pin flag sets in any phase.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_reg <= 1'h0;
      pin_s2_reg <= 1'h0;
      pin_s3_reg <= 1'h0;
      pin_level_reg <= 1'h0;
    end else begin
      pin_s1_reg <= ext_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_agree) begin
        pin_level_reg <= pin_s3_reg;
      end
    end
  end

  // Enable and flag registers.
  // [R1] Reset disables everything.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      peripheral_irq_enable_reg <= CIS_PERIPH_EN_RESET;
      edge_reg <= CIS_EDGE_RESET;
      core_en_reg <= '0;
      periph_en_reg <= '0;
      core_flag_reg <= '0;
      periph_flag_reg <= '0;
    end else begin
      if (ctrl_wr_in) begin
        peripheral_irq_enable_reg <= ctrl_wdata_in.peripheral_irq_enable;
        edge_reg <= ctrl_wdata_in.ext_edge_select;
      end
      if (core_en_wr_in) begin
        core_en_reg <= core_en_wdata_in;
      end
      if (periph_en_wr_in) begin
        periph_en_reg <= periph_en_wdata_in;
      end
      core_flag_reg <= core_flag_next;
      periph_flag_reg <= periph_flag_next;
    end
  end

  // Global enable: entry clear beats everything, return sets it.
  // [R9] Cleared enable blocks redirection.
  // [R11] Re-set enable lets pending flags in.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      global_irq_enable_reg <= CIS_GLOBAL_EN_RESET;
    end else if (accept) begin
      // [R6] Entry clears global enable.
      global_irq_enable_reg <= 1'h0;
    end else if (do_return) begin
      // [R10] Return sets global enable.
      global_irq_enable_reg <= 1'h1;
    end else if (ctrl_wr_in) begin
      global_irq_enable_reg <= ctrl_wdata_in.global_irq_enable;
    end
  end

  // Entry sequencer next state and commands.
  always_comb begin
    state_next = state_reg;
    cmd_next = '0;
    unique case (state_reg)
      CIS_ST_RUN: begin
        if (accept) begin
          // [R5] Discard prefetched instruction.
          cmd_next.flush = 1'h1;
          // [R6] Push current PC.
          cmd_next.push = 1'h1;
          // [R7] Save context to shadow.
          cmd_next.shadow_save = 1'h1;
          state_next = CIS_ST_NOP1;
        end else if (do_return) begin
          // [R10] Pop PC and restore context.
          cmd_next.pop = 1'h1;
          cmd_next.restore = 1'h1;
        end
      end
      CIS_ST_NOP1: begin
        // [R18] First forced no-operation cycle.
        cmd_next.force_nop = 1'h1;
        if (phase_reg == CIS_PHASE_FOUR) begin
          // [R8] Vector load for fetch during second cycle.
          cmd_next.pc_load = 1'h1;
          state_next = CIS_ST_NOP2;
        end
      end
      CIS_ST_NOP2: begin
        // [R18] Second forced no-operation cycle.
        cmd_next.force_nop = 1'h1;
        if (phase_reg == CIS_PHASE_FOUR) begin
          state_next = CIS_ST_RUN;
        end
      end
    endcase
  end

  // Sequencer state, command and captured values.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= CIS_ST_RUN;
      cmd_reg <= '0;
      request_reg <= 1'h0;
      push_pc_reg <= '0;
      shadow_reg <= '0;
      load_pc_reg <= CIS_VECTOR_ADDR;
    end else begin
      state_reg <= state_next;
      load_pc_reg <= CIS_VECTOR_ADDR;
      cmd_reg <= cmd_next;
      request_reg <= request_now;
      if (accept) begin
        push_pc_reg <= pc_in;
        shadow_reg <= ctx_in;
      end
    end
  end

  // Outputs straight from registers.
  assign phase_out = phase_reg;
  assign ctrl_out = '{global_irq_enable: global_irq_enable_reg,
                      peripheral_irq_enable: peripheral_irq_enable_reg,
                      ext_edge_select: edge_reg};
  assign core_en_out = core_en_reg;
  assign periph_en_out = periph_en_reg;
  // [R13] Flags visible for polling.
  assign core_flag_out = core_flag_reg;
  assign periph_flag_out = periph_flag_reg;
  assign irq_request_out = request_reg;
  assign cmd_out = cmd_reg;
  assign push_pc_out = push_pc_reg;
  assign load_pc_out = load_pc_reg;
  assign shadow_out = shadow_reg;
endmodule

/* File: cis_seq_props.sv */
// Port checker of the core interrupt sequencer.
`timescale 1ns/1ps
module cis_seq_props import cis_pkg::*; #(
  parameter int NUM_CORE = 4,
  parameter int NUM_PERIPH = 8
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [14:0] pc_in,
  input wire cis_ctx_t ctx_in,
  input wire logic [1:0] phase_out,
  input wire cis_ctrl_t ctrl_out,
  input wire cis_cmd_t cmd_out,
  input wire logic [14:0] push_pc_out,
  input wire logic [14:0] load_pc_out,
  input wire cis_ctx_t shadow_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // Entry sequence relations.
  AST_RST: assert property ($rose(resetn_in) |-> !ctrl_out.global_irq_enable)
    else $error("enable set after reset");
  AST_ENTRY: assert property (cmd_out.flush |-> cmd_out.push && cmd_out.shadow_save
    && !ctrl_out.global_irq_enable) else $error("entry steps missing");
  AST_PUSH: assert property (cmd_out.push |-> push_pc_out == $past(pc_in))
    else $error("pushed pc wrong");
  AST_SHADOW: assert property (cmd_out.shadow_save |-> shadow_out == $past(ctx_in))
    else $error("shadow wrong");
  AST_VECTOR: assert property (cmd_out.flush |-> ##[2:6] cmd_out.pc_load
    && load_pc_out == CIS_VECTOR_ADDR) else $error("no vector load");
  AST_NOPS: assert property (cmd_out.flush |=> cmd_out.force_nop [*7]
    ##1 !cmd_out.force_nop) else $error("nop count wrong");
  AST_PHASE: assert property (cmd_out.flush |-> $past(phase_out) == CIS_PHASE_ONE)
    else $error("accept off phase one");
  AST_HOLD: assert property (!ctrl_out.global_irq_enable |=> !cmd_out.flush)
    else $error("entry with enable clear");
endmodule
bind cis_core_irq_seq cis_seq_props #(.NUM_CORE(NUM_CORE), .NUM_PERIPH(NUM_PERIPH)) u_props (.*);

/* File: cis_core_model.sv */
// Behavioural core that steps and redirects the program counter.
`timescale 1ns/1ps
module cis_core_model import cis_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic stall_in,
  input wire cis_cmd_t cmd_in,
  input wire logic [14:0] load_pc_in,
  input wire logic [1:0] phase_in,
  output logic boundary_out,
  output logic [14:0] pc_out
);
  // slow instruction
  // A long instruction keeps the boundary low.
  assign boundary_out = !stall_in;
  // fetch redirect
  // The PC holds through forced NOPs and jumps to the vector.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_out <= 15'h0100;
    end else if (cmd_in.pc_load) begin
      pc_out <= load_pc_in;
    end else if (phase_in == CIS_PHASE_FOUR && !cmd_in.force_nop) begin
      pc_out <= pc_out + 15'h0001;
    end
  end
endmodule

/* File: cis_core_irq_seq_tb.sv */
// Self-checking bench of the core interrupt sequencer.
`timescale 1ns/1ps
module cis_core_irq_seq_tb import cis_pkg::*;;
  logic sys_clk_in = 1'b0, resetn_in = 1'b0, ext_pin_in = 1'b0, stall = 1'b0;
  logic ctrl_wr_in = 1'b0, core_en_wr_in = 1'b0, periph_en_wr_in = 1'b0;
  logic return_from_irq_instr_in = 1'b0, instr_boundary_in, irq_request_out;
  logic [3:0] core_event_in = 4'h0, core_en_wdata_in = 4'h0, core_flag_clr_in = 4'h0;
  logic [7:0] periph_event_in = 8'h00, periph_en_wdata_in = 8'h00;
  logic [7:0] periph_flag_clr_in = 8'h00, periph_en_out, periph_flag_out;
  logic [3:0] core_en_out, core_flag_out;
  logic [14:0] pc_in, push_pc_out, load_pc_out;
  logic [1:0] phase_out;
  cis_ctrl_t ctrl_wdata_in = 3'h0, ctrl_out;
  cis_ctx_t ctx_in = 61'h0123_4567_89ab_cde, shadow_out;
  cis_cmd_t cmd_out;
  int err_count = 0, num_checks = 0;
  // Design, core model and clock.
  cis_core_irq_seq u_cis_core_irq_seq (.*);
  cis_core_model u_cis_core_model (.sys_clk_in, .resetn_in, .stall_in(stall), .cmd_in(cmd_out),
    .load_pc_in(load_pc_out), .phase_in(phase_out), .boundary_out(instr_boundary_in),
    .pc_out(pc_in));
  initial forever #50 sys_clk_in = ~sys_clk_in;
  // Compares and counts.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Writes control bits and both enable sets.
  task automatic cfg(input cis_ctrl_t c, input logic [3:0] ce, input logic [7:0] pe);
    @(posedge sys_clk_in);
    {ctrl_wr_in, core_en_wr_in, periph_en_wr_in} <= 3'h7;
    {ctrl_wdata_in, core_en_wdata_in, periph_en_wdata_in} <= {c, ce, pe};
    @(posedge sys_clk_in);
    {ctrl_wr_in, core_en_wr_in, periph_en_wr_in} <= 3'h0;
  endtask
  // Pulses events, or flag clears when clr is set.
  task automatic pulse(input logic clr, input logic [3:0] c, input logic [7:0] p);
    @(posedge sys_clk_in);
    if (clr) {core_flag_clr_in, periph_flag_clr_in} <= {c, p};
    else {core_event_in, periph_event_in} <= {c, p};
    @(posedge sys_clk_in);
    {core_flag_clr_in, periph_flag_clr_in, core_event_in, periph_event_in} <= 24'h0;
    #1;
  endtask
  // Runs the return instruction, optionally starting a long instruction.
  task automatic ret(input logic st);
    @(posedge sys_clk_in);
    return_from_irq_instr_in <= 1'b1;
    stall <= st;
    @(posedge sys_clk_in);
    return_from_irq_instr_in <= 1'b0;
    #1;
  endtask
  // Waits a bounded time for entry and compares the outcome.
  task automatic wflush(input int n, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (n) if (!hit) begin
      @(posedge sys_clk_in);
      #1 hit = cmd_out.flush;
    end
    chk(hit, exp);
    if (exp && !hit) results();
  endtask
  // Reset state of control bits, flags and commands.
  task automatic t_reset();
    @(posedge sys_clk_in);
    #1 chk(ctrl_out, {CIS_GLOBAL_EN_RESET, CIS_PERIPH_EN_RESET, CIS_EDGE_RESET});
    chk({core_flag_out, periph_flag_out, cmd_out}, 32'h0);
  endtask
  // Pin edges set the flag per the edge select.
  task automatic t_pin();
    @(posedge sys_clk_in);
    ext_pin_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    #1 chk(core_flag_out, 4'h1);
    pulse(1'b1, 4'h1, 8'h00);
    @(posedge sys_clk_in);
    ext_pin_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 chk(core_flag_out, 4'h0);
    cfg(3'h0, 4'h0, 8'h00);
    ext_pin_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    #1 chk(core_flag_out, 4'h0);
    @(posedge sys_clk_in);
    ext_pin_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 chk(core_flag_out, 4'h1);
    pulse(1'b1, 4'h1, 8'h00);
  endtask
  // Gating, entry, vector and events inside the handler.
  task automatic t_entry();
    cfg(3'h5, 4'h2, 8'h01);
    pulse(1'b0, 4'h0, 8'h01);
    chk(periph_flag_out, 8'h01);
    chk({core_en_out, periph_en_out}, 12'h201);
    wflush(12, 1'b0);
    chk(irq_request_out, 1'b0);
    cfg(3'h7, 4'h2, 8'h01);
    wflush(12, 1'b1);
    chk(ctrl_out, 3'h3);
    chk(periph_flag_out, 8'h01);
    repeat (8) if (!cmd_out.pc_load) begin
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    #1 chk(pc_in, 15'h0004);
    pulse(1'b0, 4'h2, 8'h00);
    wflush(12, 1'b0);
    chk(core_flag_out, 4'h2);
  endtask
  // Return, late boundary, pending service and cleared flags.
  task automatic t_again();
    pulse(1'b1, 4'h0, 8'h01);
    ret(1'b1);
    chk(ctrl_out, 3'h7);
    chk({cmd_out.pop, cmd_out.restore}, 2'h3);
    wflush(8, 1'b0);
    chk(irq_request_out, 1'b1);
    @(posedge sys_clk_in);
    stall <= 1'b0;
    wflush(12, 1'b1);
    repeat (12) @(posedge sys_clk_in);
    pulse(1'b1, 4'h2, 8'h00);
    ret(1'b0);
    wflush(12, 1'b0);
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_pin();
    t_entry();
    t_again();
    results();
  end
endmodule
